// ### shared/usart_regs.svh
// Purpose: Register offsets, field positions and reset values of the USART datapath
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef USART_REGS_SVH
`define USART_REGS_SVH
`define OFS_DATA        8'h00
`define OFS_STAT_A      8'h04
`define OFS_CTRL_B      8'h08
`define OFS_CTRL_C      8'h0c
`define OFS_BAUD        8'h10
// Status A fields
`define STA_TXC_BIT     6
`define STA_UDRE_BIT    5
`define STA_RXC_BIT     7
// Control B fields
`define CTB_RXCIE_BIT   7
`define CTB_TXCIE_BIT   6
`define CTB_UDRIE_BIT   5
`define CTB_RXEN_BIT    4
`define CTB_TX_ON_BIT   3
`define CTB_SIZE2_BIT   2
`define CTB_RXB8_BIT    1
`define CTB_TX_NINTH_BIT 0
// Control C fields
`define CTC_SYNC_BIT    6
`define CTC_PM_HI_BIT   5
`define CTC_PM_LO_BIT   4
`define CTC_STOP2_BIT   3
`define CTC_SIZE_HI     2
`define CTC_SIZE_LO     1
`define CTC_POL_BIT     0
`define CTC_RESET       8'h06
`define BAUD_RESET      16'h0000
`define SIZE_NINE       3'h7
`define SIZE_EIGHT      3'h3
`endif

// ### shared/usart_pkg.sv
// Purpose: Types of the USART datapath
// Assumes: Used by the datapath only; the bench does not import it
// Notes:   Offsets and counts live in usart_regs.svh
package usart_pkg;
   typedef enum logic [4:0] {
      TX_IDLE   = 5'b00001,
      TX_START  = 5'b00010,
      TX_DATA   = 5'b00100,
      TX_PARITY = 5'b01000,
      TX_STOP   = 5'b10000
   } tx_state_t;
   typedef enum logic [3:0] {
      RX_IDLE   = 4'b0001,
      RX_START  = 4'b0010,
      RX_DATA   = 4'b0100,
      RX_STOP   = 4'b1000
   } rx_state_t;
endpackage

// ### rtl/usart_datapath.sv
// Purpose: USART transmit and receive datapath with AXI4-Lite registers
// Assumes: aclk 10 MHz; serial inputs asynchronous, three-flop synchronised
// Notes:   Interrupt requests are levels; global enable is an input
//
// Contract
// - Buffer-empty flag reads one when buffer empty, zero while pending.
// - Buffer-empty request stays asserted while enabled and flag set, globally gated.
// - Writing data location clears buffer-empty flag.
// - Complete flag sets after frame shifted out with buffer empty.
// - Complete flag clears on interrupt service or writing one.
// - Complete request raised when flag set and enabled, globally gated.
// - Upper parity bit inserts parity after data before first stop.
// - Clearing transmit enable waits until shifter and buffer finish.
// - Once disabled, transmitter releases the serial output pin.
// - Receiver enable takes over serial input pin.
// - Synchronous mode takes bit timing from external clock pin.
// - Reception starts on valid start bit, bits sampled at bit rate.
// - Receiver ignores second stop bit.
// - On first stop bit frame moves into receive buffer.
// - Unused upper received bits read zero for short characters.
// - Frame: low start, data LSB first, optional parity, high stops; idle high.
// - Shifter loads buffer when idle or right after last stop bit.
// - Parity is xor of data, inverted for odd.
// - Transmit enable makes serial output pin the transmitter output.
`timescale 1ns/1ps
`include "usart_regs.svh"
module usart_datapath
   import usart_pkg::*;
#(
   parameter int BAUD_W = 16
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Interrupts
   input  wire logic        global_irq_enable,
   input  wire logic        tx_complete_irq_ack,
   output logic             tx_empty_irq,
   output logic             tx_complete_irq,
   output logic             rx_complete_irq,
   // Serial pins
   input  wire logic        serial_in_pin,
   output logic             serial_out_pin,
   output logic             serial_out_oe,
   input  wire logic        ext_serial_clock_pin,
   output logic             rx_pin_owned
);
   // Bus state
   logic              aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
   logic [7:0]        awaddr_ff;
   logic [31:0]       wdata_ff, rdata_ff;
   logic [1:0]        bresp_ff, rresp_ff;
   // Registers
   logic [7:0]        ctrl_status_b_ff, ctrl_status_c_ff;
   logic [BAUD_W-1:0] baud_ff;
   logic [8:0]        tx_buf_ff, rx_buf_ff;
   logic              tx_full_ff, tx_complete_flag_ff, rx_full_ff, tx_active_ff;
   // Transmit engine
   tx_state_t         tx_state_ff;
   logic [8:0]        tx_shift_ff;
   logic [3:0]        tx_cnt_ff;
   logic              tx_par_ff, tx_line_ff;
   // Receive engine
   rx_state_t         rx_state_ff;
   logic [8:0]        rx_shift_ff;
   logic [3:0]        rx_cnt_ff, rx_os_ff;
   logic [2:0]        rxd_sync_ff, xck_sync_ff;
   logic              rxd_ff, xck_ff, xck_prev_ff;
   // Baud ticks
   logic [BAUD_W-1:0] div_ff;
   logic [3:0]        os_ff;
   logic              os_tick, bit_tick, sync_tick, tx_tick, rx_sample;

   function automatic logic [3:0] data_bits(input logic [2:0] sz);
      unique case (sz)
         3'h0:    return 4'h5;
         3'h1:    return 4'h6;
         3'h2:    return 4'h7;
         3'h7:    return 4'h9;
         default: return 4'h8;
      endcase
   endfunction

   function automatic logic [8:0] size_mask(input logic [8:0] d, input logic [3:0] n);
      return d & 9'(({9'h0, 9'h1ff} >> (4'h9 - n)));
   endfunction

   wire logic [2:0] char_size_select = {ctrl_status_b_ff[`CTB_SIZE2_BIT],
                                        ctrl_status_c_ff[`CTC_SIZE_HI:`CTC_SIZE_LO]};
   wire logic [3:0] nbits            = data_bits(char_size_select);
   wire logic       transmitter_enable = ctrl_status_b_ff[`CTB_TX_ON_BIT];
   wire logic       receiver_enable  = ctrl_status_b_ff[`CTB_RXEN_BIT];
   wire logic       parity_mode_upper = ctrl_status_c_ff[`CTC_PM_HI_BIT];
   wire logic       sync_mode        = ctrl_status_c_ff[`CTC_SYNC_BIT];

   // AXI write channel: address and data taken in either order
   wire logic aw_hs = s_axi_awvalid && s_axi_awready;
   wire logic w_hs  = s_axi_wvalid && s_axi_wready;
   assign s_axi_awready = !aw_got_ff && !bvalid_ff;
   assign s_axi_wready  = !w_got_ff && !bvalid_ff;
   wire logic       wr_go   = aw_got_ff && w_got_ff;
   wire logic       wr_data = wr_go && awaddr_ff == `OFS_DATA;
   wire logic       wr_sta  = wr_go && awaddr_ff == `OFS_STAT_A;
   wire logic       wr_ctb  = wr_go && awaddr_ff == `OFS_CTRL_B;
   wire logic       wr_ctc  = wr_go && awaddr_ff == `OFS_CTRL_C;
   wire logic       wr_bd   = wr_go && awaddr_ff == `OFS_BAUD;
   wire logic       wr_ok   = wr_data || wr_sta || wr_ctb || wr_ctc || wr_bd;
   logic [3:0]      wstrb_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff  <= 32'h0;
         wstrb_ff  <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= 2'h0;
      end else begin
         if (aw_hs) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (w_hs) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_ok ? 2'h0 : 2'h2;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp  = bresp_ff;

   // Byte lane 0 gates every field, the whole baud word included; lane 1 is ignored
   wire logic lane0 = wstrb_ff[0];

   // Read channel: one cycle from address to data
   assign s_axi_arready = !rvalid_ff;
   wire logic ar_hs = s_axi_arvalid && s_axi_arready;
   wire logic rd_data = ar_hs && {s_axi_araddr[7:2], 2'b00} == `OFS_DATA;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff      <= 1'b0;
         rdata_ff       <= 32'h0;
         rresp_ff       <= 2'h0;
      end else if (ar_hs) begin
         rvalid_ff      <= 1'b1;
         rresp_ff       <= 2'h0;
         unique case ({s_axi_araddr[7:2], 2'b00})
            `OFS_DATA:   rdata_ff <= {24'h0, rx_buf_ff[7:0]};
            `OFS_STAT_A: rdata_ff <= {24'h0, rx_full_ff, tx_complete_flag_ff, !tx_full_ff, 5'h0};
            `OFS_CTRL_B: rdata_ff <= {24'h0, ctrl_status_b_ff[7:2], rx_buf_ff[8], ctrl_status_b_ff[0]};
            `OFS_CTRL_C: rdata_ff <= {24'h0, ctrl_status_c_ff};
            `OFS_BAUD:   rdata_ff <= 32'(baud_ff);
            default: begin
               rdata_ff <= 32'h0;
               rresp_ff <= 2'h2;
            end
         endcase
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata  = rdata_ff;
   assign s_axi_rresp  = rresp_ff;

   // Control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_status_b_ff <= 8'h00;
         ctrl_status_c_ff <= `CTC_RESET;
         baud_ff          <= `BAUD_RESET;
      end else begin
         if (wr_ctb && lane0)
            ctrl_status_b_ff <= wdata_ff[7:0];
         if (wr_ctc && lane0)
            ctrl_status_c_ff <= wdata_ff[7:0];
         if (wr_bd && lane0)
            baud_ff <= BAUD_W'(wdata_ff[15:0]);
      end
   end

   // Input synchronisers; first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxd_sync_ff <= 3'b111;
         xck_sync_ff <= 3'b000;
         rxd_ff      <= 1'b1;
         xck_ff      <= 1'b0;
         xck_prev_ff <= 1'b0;
      end else begin
         rxd_sync_ff <= {rxd_sync_ff[1:0], serial_in_pin};
         xck_sync_ff <= {xck_sync_ff[1:0], ext_serial_clock_pin};
         if (rxd_sync_ff[1] == rxd_sync_ff[2])
            rxd_ff <= rxd_sync_ff[2];
         if (xck_sync_ff[1] == xck_sync_ff[2])
            xck_ff <= xck_sync_ff[2];
         xck_prev_ff <= xck_ff;
      end
   end

   // Baud divider: sixteen oversample ticks per bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_ff <= '0;
         os_ff  <= 4'h0;
      end else if (div_ff == baud_ff) begin
         div_ff <= '0;
         os_ff  <= os_ff + 4'h1;
      end else begin
         div_ff <= div_ff + BAUD_W'(1);
      end
   end
   assign os_tick  = div_ff == baud_ff;
   assign bit_tick = os_tick && os_ff == 4'hf;
   wire logic pol = ctrl_status_c_ff[`CTC_POL_BIT];
   wire logic xck_rise = xck_ff && !xck_prev_ff;
   wire logic xck_fall = !xck_ff && xck_prev_ff;
   assign sync_tick = pol ? xck_fall : xck_rise;
   assign tx_tick   = sync_mode ? sync_tick : bit_tick;
   assign rx_sample = sync_mode ? (pol ? xck_rise : xck_fall) : 1'b0;

   // Transmit buffer and flags
   // Buffered character still drains after the enable drops
   wire logic tx_load  = tx_full_ff && (tx_state_ff == TX_IDLE || (tx_state_ff == TX_STOP && tx_tick
                                         && (tx_cnt_ff == 4'h0)) ) && (transmitter_enable || tx_active_ff);
   wire logic tx_done  = tx_state_ff == TX_STOP && tx_tick && tx_cnt_ff == 4'h0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_buf_ff  <= 9'h0;
         tx_full_ff <= 1'b0;
      end else begin
         if (wr_data && lane0) begin
            tx_buf_ff  <= {ctrl_status_b_ff[`CTB_TX_NINTH_BIT], wdata_ff[7:0]};
            tx_full_ff <= 1'b1;
         end else if (tx_load) begin
            tx_full_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         tx_complete_flag_ff <= 1'b0;
      else if (tx_done && !tx_full_ff)
         tx_complete_flag_ff <= 1'b1;
      else if (tx_complete_irq_ack || (wr_sta && lane0 && wdata_ff[`STA_TXC_BIT]))
         tx_complete_flag_ff <= 1'b0;
   end

   function automatic logic parity_of(input logic [8:0] d, input logic odd);
      return (^d) ^ odd;
   endfunction

   // Transmit state machine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_state_ff <= TX_IDLE;
         tx_shift_ff <= 9'h0;
         tx_cnt_ff   <= 4'h0;
         tx_par_ff   <= 1'b0;
         tx_line_ff  <= 1'b1;
      end else begin
         unique case (tx_state_ff)
            TX_IDLE: begin
               tx_line_ff <= 1'b1;
               if (tx_load) begin
                  tx_shift_ff <= size_mask(tx_buf_ff, nbits);
                  tx_par_ff   <= parity_of(size_mask(tx_buf_ff, nbits), ctrl_status_c_ff[`CTC_PM_LO_BIT]);
                  tx_state_ff <= TX_START;
               end
            end
            TX_START: if (tx_tick) begin
               tx_line_ff  <= 1'b0;
               tx_cnt_ff   <= nbits;
               tx_state_ff <= TX_DATA;
            end
            TX_DATA: if (tx_tick) begin
               if (tx_cnt_ff == 4'h0) begin
                  tx_line_ff  <= parity_mode_upper ? tx_par_ff : 1'b1;
                  tx_cnt_ff   <= ctrl_status_c_ff[`CTC_STOP2_BIT] ? 4'h1 : 4'h0;
                  tx_state_ff <= parity_mode_upper ? TX_PARITY : TX_STOP;
               end else begin
                  tx_line_ff  <= tx_shift_ff[0];
                  tx_shift_ff <= {1'b0, tx_shift_ff[8:1]};
                  tx_cnt_ff   <= tx_cnt_ff - 4'h1;
               end
            end
            TX_PARITY: if (tx_tick) begin
               tx_line_ff  <= 1'b1;
               tx_state_ff <= TX_STOP;
            end
            TX_STOP: if (tx_tick) begin
               tx_line_ff <= 1'b1;
               if (tx_cnt_ff != 4'h0) begin
                  tx_cnt_ff <= tx_cnt_ff - 4'h1;
               end else if (tx_load) begin
                  tx_shift_ff <= size_mask(tx_buf_ff, nbits);
                  tx_par_ff   <= parity_of(size_mask(tx_buf_ff, nbits), ctrl_status_c_ff[`CTC_PM_LO_BIT]);
                  tx_state_ff <= TX_START;
               end else begin
                  tx_state_ff <= TX_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         tx_active_ff <= 1'b0;
      else if (transmitter_enable)
         tx_active_ff <= 1'b1;
      else if (tx_state_ff == TX_IDLE && !tx_full_ff)
         tx_active_ff <= 1'b0;
   end
   assign serial_out_oe  = tx_active_ff;
   assign serial_out_pin = tx_line_ff;

   assign tx_empty_irq    = global_irq_enable && ctrl_status_b_ff[`CTB_UDRIE_BIT] && !tx_full_ff;
   assign tx_complete_irq = global_irq_enable && ctrl_status_b_ff[`CTB_TXCIE_BIT] && tx_complete_flag_ff;
   assign rx_complete_irq = global_irq_enable && ctrl_status_b_ff[`CTB_RXCIE_BIT] && rx_full_ff;

   assign rx_pin_owned = receiver_enable;
   wire logic rx_bit = rxd_ff;
   wire logic rx_tick = sync_mode ? rx_sample : (os_tick && rx_os_ff == 4'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn || !receiver_enable) begin
         rx_state_ff <= RX_IDLE;
         rx_shift_ff <= 9'h0;
         rx_cnt_ff   <= 4'h0;
         rx_os_ff    <= 4'h0;
      end else begin
         if (os_tick)
            rx_os_ff <= rx_os_ff - 4'h1;
         unique case (rx_state_ff)
            RX_IDLE: if (!rx_bit && (sync_mode ? rx_sample : os_tick)) begin
               rx_os_ff    <= sync_mode ? 4'h0 : 4'h7;
               rx_state_ff <= sync_mode ? RX_DATA : RX_START;
               rx_cnt_ff   <= nbits;
            end
            RX_START: if (rx_tick) begin
               // Majority not used; glitch returns to idle
               rx_state_ff <= rx_bit ? RX_IDLE : RX_DATA;
            end
            RX_DATA: if (rx_tick) begin
               // Parity bit is sampled but kept out of the shifter
               if (rx_cnt_ff != 4'h0) begin
                  rx_shift_ff <= {rx_bit, rx_shift_ff[8:1]};
                  rx_cnt_ff   <= rx_cnt_ff - 4'h1;
               end
               if (rx_cnt_ff == 4'h0 || (rx_cnt_ff == 4'h1 && !parity_mode_upper))
                  rx_state_ff <= RX_STOP;
            end
            RX_STOP: if (rx_tick) begin
               rx_state_ff <= RX_IDLE;
            end
         endcase
      end
   end

   wire logic rx_frame_done = receiver_enable && rx_state_ff == RX_STOP && rx_tick;
   wire logic [8:0] rx_aligned = rx_shift_ff >> (4'h9 - nbits);
   always_ff @(posedge aclk) begin
      if (!aresetn || !receiver_enable) begin
         rx_buf_ff  <= 9'h0;
         rx_full_ff <= 1'b0;
      end else if (rx_frame_done) begin
         rx_buf_ff  <= size_mask(rx_aligned, nbits);
         rx_full_ff <= 1'b1;
      end else if (rd_data) begin
         rx_full_ff <= 1'b0;
      end
   end

   // Assertions
   a_empty_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_data && lane0) |=> tx_full_ff) else $error("write did not clear empty");
   a_empty_irq: assert property (@(posedge aclk) disable iff (!aresetn)
      (global_irq_enable && ctrl_status_b_ff[`CTB_UDRIE_BIT] && !tx_full_ff) |-> tx_empty_irq)
      else $error("empty request missing");
   a_txc_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (tx_done && !tx_full_ff) |=> tx_complete_flag_ff) else $error("complete flag not set");
   a_txc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (tx_complete_irq_ack && !(tx_done && !tx_full_ff)) |=> !tx_complete_flag_ff)
      else $error("complete flag not cleared");
   a_txc_irq: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(tx_complete_flag_ff) && global_irq_enable && ctrl_status_b_ff[`CTB_TXCIE_BIT] |-> tx_complete_irq)
      else $error("complete request missing");
   a_start_low: assert property (@(posedge aclk) disable iff (!aresetn)
      (tx_state_ff == TX_START && tx_tick) |=> !serial_out_pin) else $error("start bit not low");
   a_idle_high: assert property (@(posedge aclk) disable iff (!aresetn)
      (tx_state_ff == TX_IDLE) |-> ##1 (serial_out_pin || tx_state_ff == TX_START))
      else $error("idle line not high");
   a_drain_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (tx_full_ff || tx_state_ff != TX_IDLE) && tx_active_ff |=> serial_out_oe)
      else $error("pin released while busy");
   a_pin_release: assert property (@(posedge aclk) disable iff (!aresetn)
      (!transmitter_enable && tx_state_ff == TX_IDLE && !tx_full_ff) |=> !serial_out_oe)
      else $error("pin not released");
   a_rx_buffer: assert property (@(posedge aclk) disable iff (!aresetn)
      rx_frame_done |=> rx_full_ff) else $error("frame not buffered");
   c_tx_frame: cover property (@(posedge aclk) disable iff (!aresetn) tx_done ##1 tx_complete_flag_ff);
   c_back2back: cover property (@(posedge aclk) disable iff (!aresetn) tx_done && tx_load);
   c_rx_frame: cover property (@(posedge aclk) disable iff (!aresetn) rx_frame_done);
endmodule

// ### tb/serial_node.sv
// Purpose: Remote serial node facing the USART
// Assumes: Baud divider 0, so 16 clocks per bit
// Notes:   Sends one stop bit; records nine bits per frame
`timescale 1ns/1ps
module serial_node (
   // Clock
   input  wire logic aclk,
   // Serial lines
   input  wire logic from_dut,
   output logic      to_dut
);
   logic [8:0] got[$];
   logic [8:0] v;
   initial to_dut = 1'b1;
   task automatic send(input logic [7:0] b);
      to_dut <= 1'b0;
      repeat (16) @(posedge aclk);
      for (int i = 0; i < 9; i++) begin
         to_dut <= (i < 8) ? b[i] : 1'b1;
         repeat (16) @(posedge aclk);
      end
   endtask
   // Mid-bit sampling; ninth bit is parity, stop or data bit 8
   always begin
      @(negedge from_dut);
      repeat (8) @(posedge aclk);
      for (int i = 0; i < 9; i++) begin
         repeat (16) @(posedge aclk);
         v[i] = from_dut;
      end
      got.push_back(v);
   end
endmodule

// ### tb/serial_usart_tx_rx_datapath_tb.sv
// Purpose: Self-checking bench of the USART datapath
// Assumes: Baud divider left at 0
// Notes:   Handshakes sampled at falling edge, driven after rising
`timescale 1ns/1ps
`include "usart_regs.svh"
module serial_usart_tx_rx_datapath_tb;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, global_irq_enable;
   logic        tx_complete_irq_ack, tx_empty_irq, tx_complete_irq, rx_complete_irq, serial_in_pin;
   logic        serial_out_pin, serial_out_oe, ext_serial_clock_pin, rx_pin_owned;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   wire         line = serial_out_oe ? serial_out_pin : 1'b1;
   int          n_errors, cmp_count;
   logic [3:0]  xck_div = 4'h0;
   logic        xck_run = 1'b0;
   usart_datapath uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .global_irq_enable, .tx_complete_irq_ack, .tx_empty_irq, .tx_complete_irq, .rx_complete_irq,
      .serial_in_pin, .serial_out_pin, .serial_out_oe, .ext_serial_clock_pin, .rx_pin_owned);
   serial_node node (.aclk, .from_dut(line), .to_dut(serial_in_pin));
   always #50 aclk = ~aclk;
   // Slave serial clock, 16 aclk per bit so the node samples alike
   always @(posedge aclk) begin
      if (xck_run) begin
         xck_div <= xck_div + 4'h1;
         ext_serial_clock_pin <= xck_div[3];
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: %h, not %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, bv;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         bv = s_axi_bvalid;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (bv !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta, rv;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_arvalid & s_axi_arready;
         rv = s_axi_rvalid;
         d = s_axi_rdata;
         rr = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end while (rv !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a);
      chk(d & m, e);
   endtask
   // Polls a status bit; bounded so a stuck flag cannot hang
   task automatic wst(input int b);
      int n;
      n = 0;
      do begin
         rd(`OFS_STAT_A);
         n++;
      end while (d[b] !== 1'b1 && n < 400);
      chk(d[b], 1'b1);
   endtask
   task automatic fr(input logic [8:0] e);
      chk(node.got.size() > 0 ? node.got.pop_front() : 32'hx, e);
   endtask
   task automatic results();
      if (n_errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_complete_irq_ack, ext_serial_clock_pin} = '0;
      s_axi_wstrb = 4'hf;
      global_irq_enable = 1'b1;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rc(`OFS_STAT_A, 32'he0, 32'h20);
      rc(`OFS_CTRL_C, 32'hff, `CTC_RESET);
      rc(8'h20, 32'hffffffff, 32'h0);
      chk(rr, 2'b10);
      wr(`OFS_CTRL_B, 32'h78);
      @(negedge aclk);
      chk({tx_empty_irq, serial_out_oe, rx_pin_owned}, 3'b111);
      wr(`OFS_DATA, 32'ha5);
      wst(5);
      wr(`OFS_DATA, 32'h3c);
      rc(`OFS_STAT_A, 32'h20, 32'h0);
      chk(tx_empty_irq, 1'b0);
      wst(6);
      chk(tx_complete_irq, 1'b1);
      fr(9'h1a5);
      fr(9'h13c);
      wr(`OFS_STAT_A, 32'h40);
      rc(`OFS_STAT_A, 32'h60, 32'h20);
      for (int i = 0; i < 2; i++) begin
         wr(`OFS_CTRL_C, 32'h26 | (i << 4));
         wr(`OFS_DATA, 32'h07);
         wst(6);
         fr({^8'h07 ^ i[0], 8'h07});
         tx_complete_irq_ack <= 1'b1;
         @(posedge aclk);
         tx_complete_irq_ack <= 1'b0;
         rc(`OFS_STAT_A, 32'h40, 32'h0);
      end
      wr(`OFS_CTRL_C, 32'h06);
      wr(`OFS_CTRL_B, 32'h1d);
      wr(`OFS_DATA, 32'h81);
      wr(`OFS_CTRL_B, 32'h1c);
      wst(6);
      fr(9'h181);
      wr(`OFS_STAT_A, 32'h40);
      wr(`OFS_CTRL_B, 32'h18);
      wr(`OFS_DATA, 32'h11);
      wst(5);
      wr(`OFS_DATA, 32'h22);
      wr(`OFS_CTRL_B, 32'h10);
      chk(serial_out_oe, 1'b1);
      wst(6);
      repeat (4) @(posedge aclk);
      fr(9'h111);
      fr(9'h122);
      chk(serial_out_oe, 1'b0);
      wr(`OFS_CTRL_C, 32'h0e);
      node.send(8'h5a);
      rc(`OFS_STAT_A, 32'h80, 32'h80);
      rc(`OFS_DATA, 32'h1ff, 32'h5a);
      wr(`OFS_CTRL_C, 32'h04);
      node.send(8'hd5);
      wst(7);
      rc(`OFS_DATA, 32'hff, 32'h55);
      xck_run <= 1'b1;
      wr(`OFS_STAT_A, 32'h40);
      wr(`OFS_CTRL_C, 32'h46);
      wr(`OFS_CTRL_B, 32'h18);
      wr(`OFS_DATA, 32'h96);
      wst(6);
      fr(9'h196);
      results();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      results();
   end
endmodule
